/* design/odsc_regs.vh */
// Named constants for the octal driver serial command and status port.
// Assumes inclusion by bare name from the design files.
`ifndef ODSC_REGS_VH
`define ODSC_REGS_VH
`define ODSC_WORD_W 16
`define ODSC_CNT_W 5
`define ODSC_FRAME_BITS 5'h10
`define ODSC_CNT_ONE 5'h01
`define ODSC_CMD_RST 16'h0000
`define ODSC_STS_RST 16'h0000
`define ODSC_CMD_DRV_LO 0
`define ODSC_CMD_DRV_HI 7
`define ODSC_CMD_OL_LO 8
`define ODSC_CMD_OL_HI 15
`define ODSC_ST_TW 0
`define ODSC_ST_FLT_LO 1
`define ODSC_ST_FLT_HI 8
`define ODSC_ST_PAR_LO 9
`define ODSC_ST_PAR_HI 12
`define ODSC_ST_SPARE_LO 13
`define ODSC_ST_SPARE_HI 14
`define ODSC_ST_SUP 15
`define ODSC_CLK_NS 5
`define ODSC_CLK_MHZ 200
`define ODSC_SO_EN_NS 50
`define ODSC_SO_EN_CYC (`ODSC_SO_EN_NS / `ODSC_CLK_NS)
`define ODSC_WAKE_US 200
`define ODSC_WAKE_CYC (`ODSC_WAKE_US * `ODSC_CLK_MHZ)
`define ODSC_WAKE_W 16
`endif

/* design/odsc_shift.v */
// 16-bit serial shift engine: receive and transmit registers, bit counter.
// Assumes one-cycle sample, shift and load strobes from the port controller.
`timescale 1ns/1ps
`include "odsc_regs.vh"
module odsc_shift #(
  parameter W = `ODSC_WORD_W,
  parameter CW = `ODSC_CNT_W
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire load_in,
  input wire [W-1:0] load_word_in,
  input wire sample_in,
  input wire shift_in,
  input wire sdi_in,
  output wire [W-1:0] rx_word_out,
  output wire tx_bit_out,
  output wire [CW-1:0] bit_cnt_out
);
  reg [W-1:0] rx_q;
  reg [W-1:0] tx_q;
  reg [CW-1:0] cnt_q;
  // =========================================
  // Shift registers
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rx_q <= {W{1'b0}};
      tx_q <= {W{1'b0}};
      cnt_q <= {CW{1'b0}};
    end
    else if (load_in)
    begin
      tx_q <= load_word_in;
      rx_q <= {W{1'b0}};
      cnt_q <= {CW{1'b0}};
    end
    else
    begin
      if (sample_in)
      begin
        rx_q <= {sdi_in, rx_q[W-1:1]};
        // Saturate so long frames never wrap back to a full count
        if (cnt_q != {CW{1'b1}})
          cnt_q <= cnt_q + `ODSC_CNT_ONE;
      end
      if (shift_in)
        tx_q <= {1'b0, tx_q[W-1:1]};
    end
  end
  assign rx_word_out = rx_q;
  assign tx_bit_out = tx_q[0];
  assign bit_cnt_out = cnt_q;
endmodule // odsc_shift

/* design/odsc_top.v */
// Serial command and status port of an octal power-switch driver.
// Assumes a mode-0 host (clock low at select edges) and fault flags from
// detection logic on the same clock; pins are synchronised here.
//
// Summary of operation
// - One 16-bit word each way per frame
// - Least significant bit shifted first, both directions
// - Command bits 0-7 switch drivers 1-8
// - Command bits 8-15 enable open-load diagnostics
// - Status bits 1-8 report driver faults
// - Driver fault: open load, over-current, over-temperature
// - Flags 1 means fault; bit0 warning, bit15 supply
// - Status bits 9-12 mirror parallel inputs 5-8
// - Capture parallel inputs on over-current or shutdown
// - Command and status registers reset to zero
// - Output enabled and released within 50 ns
// - Port operational within 200 us after enable
`timescale 1ns/1ps
`include "odsc_regs.vh"
module odsc_top #(
  parameter W = `ODSC_WORD_W,
  parameter CW = `ODSC_CNT_W,
  parameter WAKE_CYC = `ODSC_WAKE_CYC,
  parameter WKW = `ODSC_WAKE_W
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire chip_select_n_in,
  input wire sclk_in,
  input wire sdi_in,
  input wire enable_in,
  input wire [3:0] par_in,
  input wire [7:0] drv_fault_in,
  input wire oc_tsd_event_in,
  input wire thermal_warning_flag_in,
  input wire supply_fail_in,
  output wire sdo_out,
  output wire sdo_oe_out,
  output wire [7:0] drv_on_out,
  output wire [7:0] ol_diag_en_out,
  output wire [W-1:0] status_word_out,
  output wire spi_ready_out,
  output wire frame_done_out
);
  localparam [3:0] ST_OFF = 4'h1;
  localparam [3:0] ST_WAKE = 4'h2;
  localparam [3:0] ST_IDLE = 4'h4;
  localparam [3:0] ST_FRAME = 4'h8;
  localparam integer WAKE_LAST_I = WAKE_CYC - 1;
  localparam [WKW-1:0] WAKE_LAST = WAKE_LAST_I[WKW-1:0];
  localparam [WKW-1:0] WAKE_ZERO = {WKW{1'b0}};
  localparam [WKW-1:0] WAKE_ONE = {{(WKW-1){1'b0}}, 1'b1};

  function edge_up;
    input cur;
    input prev;
    begin
      edge_up = cur & ~prev;
    end
  endfunction

  // =========================================
  // Pin synchronisers
  reg [3:0] cs_s1_q, cs_s2_q;
  reg [3:0] par_s1_q, par_s2_q;
  reg cs_p_q, sclk_p_q, en_p_q;
  wire cs_n = cs_s2_q[0];
  wire sclk = cs_s2_q[1];
  wire sdi = cs_s2_q[2];
  wire en = cs_s2_q[3];
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      // Select idles high so no false falling edge after reset
      cs_s1_q <= 4'h1;
      cs_s2_q <= 4'h1;
      par_s1_q <= 4'h0;
      par_s2_q <= 4'h0;
      cs_p_q <= 1'b1;
      sclk_p_q <= 1'b0;
      en_p_q <= 1'b0;
    end
    else
    begin
      cs_s1_q <= {enable_in, sdi_in, sclk_in, chip_select_n_in};
      cs_s2_q <= cs_s1_q;
      par_s1_q <= par_in;
      par_s2_q <= par_s1_q;
      cs_p_q <= cs_n;
      sclk_p_q <= sclk;
      en_p_q <= en;
    end
  end
  wire cs_fall = edge_up(cs_p_q, cs_n);
  wire cs_rise = edge_up(cs_n, cs_p_q);
  wire sclk_rise = edge_up(sclk, sclk_p_q);
  wire sclk_fall = edge_up(sclk_p_q, sclk);
  wire en_rise = edge_up(en, en_p_q);

  // =========================================
  // Wake-up and frame control
  reg [3:0] state_q, state_d;
  reg [WKW-1:0] wake_q, wake_d;
  reg oe_q, oe_d;
  wire [CW-1:0] bit_cnt;
  wire [W-1:0] rx_word;
  wire tx_bit;
  wire in_frame = state_q[3];
  wire load = (state_q == ST_IDLE) & cs_fall;
  wire commit = in_frame & cs_rise & (bit_cnt == `ODSC_FRAME_BITS);
  always @*
  begin
    state_d = state_q;
    wake_d = wake_q;
    oe_d = oe_q;
    case (state_q)
      ST_OFF:
      begin
        oe_d = 1'b0;
        if (en_rise)
        begin
          wake_d = WAKE_ZERO;
          state_d = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        // Frames during wake-up are ignored, not queued
        if (wake_q == WAKE_LAST)
          state_d = cs_n ? ST_IDLE : ST_WAKE;
        else
          wake_d = wake_q + WAKE_ONE;
      end
      ST_IDLE:
      begin
        if (cs_fall)
        begin
          oe_d = 1'b1;
          state_d = ST_FRAME;
        end
      end
      ST_FRAME:
      begin
        if (cs_rise)
        begin
          oe_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        oe_d = 1'b0;
        state_d = ST_OFF;
      end
    endcase
    if (!en)
    begin
      oe_d = 1'b0;
      state_d = ST_OFF;
    end
  end
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_q <= ST_OFF;
      wake_q <= WAKE_ZERO;
      oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      wake_q <= wake_d;
      oe_q <= oe_d;
    end
  end

  // =========================================
  // Command register
  reg [W-1:0] cmd_q;
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cmd_q <= `ODSC_CMD_RST;
    else if (!en)
      // Cycling enable clears the command like a power-on
      cmd_q <= `ODSC_CMD_RST;
    else if (commit)
      cmd_q <= rx_word;
  end
  assign drv_on_out = cmd_q[`ODSC_CMD_DRV_HI:`ODSC_CMD_DRV_LO];
  assign ol_diag_en_out = cmd_q[`ODSC_CMD_OL_HI:`ODSC_CMD_OL_LO];

  // =========================================
  // Status register
  reg [3:0] par_cap_q;
  reg hold_q;
  reg [W-1:0] sts_q;
  reg [W-1:0] sts_d;
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      par_cap_q <= 4'h0;
      hold_q <= 1'b0;
    end
    else if (oc_tsd_event_in)
    begin
      // Event beats a clearing frame in the same cycle
      par_cap_q <= par_s2_q;
      hold_q <= 1'b1;
    end
    else if (commit | !en)
      hold_q <= 1'b0;
  end
  always @*
  begin
    sts_d = `ODSC_STS_RST;
    sts_d[`ODSC_ST_TW] = thermal_warning_flag_in;
    sts_d[`ODSC_ST_FLT_HI:`ODSC_ST_FLT_LO] = drv_fault_in;
    sts_d[`ODSC_ST_PAR_HI:`ODSC_ST_PAR_LO] = hold_q ? par_cap_q : par_s2_q;
    sts_d[`ODSC_ST_SPARE_HI:`ODSC_ST_SPARE_LO] = 2'h0;
    sts_d[`ODSC_ST_SUP] = supply_fail_in;
  end
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sts_q <= `ODSC_STS_RST;
    else
      sts_q <= sts_d;
  end
  assign status_word_out = sts_q;

  // =========================================
  // Shift engine
  odsc_shift #(
    .W(W),
    .CW(CW)
  ) u_shift (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .load_in(load),
    .load_word_in(sts_q),
    .sample_in(in_frame & sclk_rise),
    .shift_in(in_frame & sclk_fall),
    .sdi_in(sdi),
    .rx_word_out(rx_word),
    .tx_bit_out(tx_bit),
    .bit_cnt_out(bit_cnt)
  );

  // =========================================
  // Outputs
  assign sdo_out = tx_bit & oe_q;
  assign sdo_oe_out = oe_q;
  assign spi_ready_out = state_q[2] | state_q[3];
  assign frame_done_out = commit;
endmodule // odsc_top

/* testbench/odsc_top_asserts.sv */
// Port checks for the serial command and status block.
// Assumes binding into odsc_top; pins are synced inside, bounds allow it.
`timescale 1ns/1ps
module odsc_chk #(
  parameter W = 16
) (
  input logic mclk_in,
  input logic nrst_in,
  input logic chip_select_n_in,
  input logic enable_in,
  input logic [7:0] drv_fault_in,
  input logic oc_tsd_event_in,
  input logic thermal_warning_flag_in,
  input logic supply_fail_in,
  input logic sdo_oe_out,
  input logic [7:0] drv_on_out,
  input logic [7:0] ol_diag_en_out,
  input logic [W-1:0] status_word_out,
  input logic spi_ready_out,
  input logic frame_done_out
);
  // ==========
  // Assertions
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  stat_follow_a: assert property ($past(nrst_in) |->
    {status_word_out[15], status_word_out[8:0]} ==
    $past({supply_fail_in, drv_fault_in, thermal_warning_flag_in})) else $error("flags wrong");
  spare_zero_a: assert property (status_word_out[14:13] == 2'b00) else $error("spare set");
  oe_on_a: assert property ($fell(chip_select_n_in) && spi_ready_out |-> ##[1:10] sdo_oe_out)
    else $error("output not enabled");
  oe_off_a: assert property ($rose(chip_select_n_in) |-> ##[1:10] !sdo_oe_out)
    else $error("output not released");
  cmd_hold_a: assert property (!frame_done_out && enable_in |=>
    $stable({ol_diag_en_out, drv_on_out})) else $error("command moved");
  commit_sel_a: assert property (frame_done_out |-> chip_select_n_in && spi_ready_out)
    else $error("commit inside frame");
  par_hold_a: assert property (oc_tsd_event_in ##1 !(frame_done_out || oc_tsd_event_in) |=>
    $stable(status_word_out[12:9])) else $error("capture lost");
  wake_quiet_a: assert property (!spi_ready_out [*3] |-> !sdo_oe_out)
    else $error("output while asleep");
  cover property (frame_done_out);
  cover property (oc_tsd_event_in);
  cover property ($rose(sdo_oe_out));
endmodule // odsc_chk
bind odsc_top odsc_chk #(.W(W)) u_chk (.mclk_in, .nrst_in, .chip_select_n_in, .enable_in,
  .drv_fault_in, .oc_tsd_event_in, .thermal_warning_flag_in, .supply_fail_in, .sdo_oe_out,
  .drv_on_out, .ol_diag_en_out, .status_word_out, .spi_ready_out, .frame_done_out);

/* testbench/odsc_host.sv */
// Serial host model: mode 0, 48 ns serial clock, idle low.
// Assumes the bench calls xfer one frame at a time.
`timescale 1ns/1ps
module odsc_host (
  output logic chip_select_n_out,
  output logic sclk_out,
  output logic sdi_out,
  input logic sdo_in
);
  // ==========
  // Frame task
  initial
  begin
    chip_select_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // Bit count other than 16 only to provoke a refusal
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] sts);
    sts = 16'h0000;
    chip_select_n_out <= 1'b0;
    #100;
    for (int i = 0; i < nbits; i++)
    begin
      sdi_out <= cmd[i % 16];
      #24;
      if (i < 16) sts[i] = sdo_in;
      sclk_out <= 1'b1;
      #24;
      sclk_out <= 1'b0;
    end
    sdi_out <= ~sdi_out;
    #100;
    chip_select_n_out <= 1'b1;
    #300;
  endtask
endmodule // odsc_host

/* testbench/testbench.sv */
// Self-checking bench for odsc_top with a shortened wake count.
// Assumes odsc_host drives the serial pins.
`timescale 1ns/1ps
module testbench;
  localparam int WAKE = 20;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic enable_in = 1'b0;
  logic [3:0] par_in = 4'h0;
  logic [7:0] drv_fault_in = 8'h00;
  logic oc_in = 1'b0;
  logic tw_in = 1'b0;
  logic sup_in = 1'b0;
  logic cs_n, sclk, sdi;
  wire sdo, oe, rdy, done;
  wire [7:0] drv_on, ol_en;
  wire [15:0] stat;
  logic [15:0] sts, c, s;
  int err_count = 0;
  int checks = 0;
  always #2.5 mclk_in = ~mclk_in;
  odsc_top #(.WAKE_CYC(WAKE)) u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .chip_select_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi), .enable_in(enable_in),
    .par_in(par_in), .drv_fault_in(drv_fault_in), .oc_tsd_event_in(oc_in),
    .thermal_warning_flag_in(tw_in), .supply_fail_in(sup_in), .sdo_out(sdo),
    .sdo_oe_out(oe), .drv_on_out(drv_on), .ol_diag_en_out(ol_en),
    .status_word_out(stat), .spi_ready_out(rdy), .frame_done_out(done));
  odsc_host u_host (.chip_select_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo));
  // ==========
  // Tasks
  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========
  // Tests
  initial
  begin
    cyc(20);
    nrst_in <= 1'b1;
    cyc(2);
    chk16("command", 16'h0000, {ol_en, drv_on});
    chk16("status", 16'h0000, stat);
    u_host.xfer(16'hffff, 16, sts);
    chk16("asleep", 16'h0000, {ol_en, drv_on});
    cyc(1);
    enable_in <= 1'b1;
    // Frame opened inside the wake window must be dropped
    u_host.xfer(16'hffff, 16, sts);
    chk16("waking", 16'h0000, {ol_en, drv_on});
    cyc(WAKE + 10);
    chk16("ready", 16'h0001, {15'h0000, rdy});
    $display("test reset and wake done");
    for (int k = 0; k < 2; k++)
    begin
      c = k ? 16'h3c96 : 16'hc369;
      s = ~c;
      cyc(1);
      tw_in <= s[0];
      drv_fault_in <= s[8:1];
      par_in <= s[12:9];
      sup_in <= s[15];
      cyc(6);
      u_host.xfer(c, 16, sts);
      chk16("sdo word", s & 16'h9fff, sts);
      chk16("command", c, {ol_en, drv_on});
      chk16("status", s & 16'h9fff, stat);
    end
    for (int n = 15; n < 18; n += 2)
    begin
      u_host.xfer(16'hffff, n, sts);
      chk16("bad length", c, {ol_en, drv_on});
    end
    $display("test frames done");
    cyc(1);
    par_in <= 4'h6;
    cyc(6);
    oc_in <= 1'b1;
    cyc(1);
    oc_in <= 1'b0;
    par_in <= 4'h3;
    cyc(8);
    chk16("held inputs", 16'h0006, {12'h000, stat[12:9]});
    u_host.xfer(16'h5aa5, 16, sts);
    chk16("live inputs", 16'h0003, {12'h000, stat[12:9]});
    chk16("command", 16'h5aa5, {ol_en, drv_on});
    cyc(1);
    nrst_in <= 1'b0;
    cyc(2);
    chk16("reset again", 16'h0000, {ol_en, drv_on});
    chk16("status", 16'h0000, stat);
    $display("test capture and reset done");
    summarize();
  end
endmodule // testbench
